// File: rtl/psc_top.sv
`timescale 1ns/1ps
`include "psc_regs.svh"

// Operation
// (RQ1) next system state follows present state and how long the switch was held
// (RQ2) off plus short press powers the system on into working
// (RQ3) working plus short press puts the system to sleep
// (RQ4) working plus long press forces soft-off
// (RQ5) sleeping plus short press wakes the system into working
// (RQ6) sleeping plus long press goes to soft-off
// (RQ7) green led dark without link, steady with link, blinking on traffic
// (RQ8) yellow led dark at the slow rate, lit at the fast rate
// (RQ9) closed chassis switch records a readable sticky intrusion event
// (RQ10) hold counted from debounced press; long fires at threshold, short on release
module psc_top
  import psc_pkg::*;
#(
  parameter int unsigned HOLD_LONG_CYC = `PSC_HOLD_LONG_CYC,
  parameter int unsigned DEBOUNCE_CYC = `PSC_DEBOUNCE_CYC,
  parameter int unsigned BLINK_HALF_CYC = `PSC_BLINK_HALF_CYC,
  parameter int unsigned ACT_HOLD_CYC = `PSC_ACT_HOLD_CYC
)
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // front panel and chassis switches
  input wire logic I_PWR_SW,
  input wire logic I_CHASSIS_SW_CLOSED,
  input wire logic I_INTRUSION_CLR,
  // network status from the controller
  input wire logic I_LINK_UP,
  input wire logic I_LINK_ACT,
  input wire logic I_LINK_FAST,
  // system state signalling
  output logic [1:0] O_SYS_STATE,
  output logic O_PSU_ON,
  output logic O_STATE_CHG,
  output logic O_INTRUSION,
  // connector leds
  output logic O_LED_GREEN,
  output logic O_LED_YELLOW
);

  // --------------------------------------------------------------------------
  // switch filtering
  // --------------------------------------------------------------------------
  logic pwr_pressed;
  logic cover_open;

  psc_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_deb_pwr (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_raw(I_PWR_SW),
    .o_level(pwr_pressed)
  );

  psc_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_deb_cover (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_raw(I_CHASSIS_SW_CLOSED),
    .o_level(cover_open)
  );

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  localparam psc_state_t ST_RST = '{
    sys: psc_sys_t'(`PSC_SYS_RST),
    psu_on: `PSC_BIT_RST,
    chg: `PSC_BIT_RST,
    sw_prev: `PSC_BIT_RST,
    long_done: `PSC_BIT_RST,
    hold_cnt: `PSC_CNT_RST,
    intrusion: `PSC_BIT_RST,
    blink_cnt: `PSC_CNT_RST,
    blink: `PSC_BIT_RST,
    act_cnt: `PSC_CNT_RST,
    led_green: `PSC_BIT_RST,
    led_yellow: `PSC_BIT_RST
  };

  psc_state_t st_r;
  psc_state_t st_nxt;
  logic press_rise;
  logic press_fall;
  logic long_hit;

  assign press_rise = pwr_pressed & ~st_r.sw_prev;
  assign press_fall = ~pwr_pressed & st_r.sw_prev;
  assign long_hit = pwr_pressed & st_r.sw_prev & ~st_r.long_done &
                    (st_r.hold_cnt >= 32'(HOLD_LONG_CYC - 1));

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.chg = 1'h0;
    st_nxt.sw_prev = pwr_pressed;

    // hold measurement restarts at every filtered press
    if (press_rise)
    begin
      st_nxt.hold_cnt = `PSC_CNT_RST; // RQ10
      st_nxt.long_done = 1'h0;
    end
    else if (long_hit)
    begin
      // long action fires while still held; the later release is then ignored
      st_nxt.long_done = 1'h1; // RQ10
      case (st_r.sys)
        PSC_SYS_WORK:
        begin
          st_nxt.sys = PSC_SYS_OFF; // RQ4
          st_nxt.chg = 1'h1;
        end
        PSC_SYS_SLEEP:
        begin
          st_nxt.sys = PSC_SYS_OFF; // RQ6
          st_nxt.chg = 1'h1;
        end
        default:
        begin
          st_nxt.sys = st_r.sys;
        end
      endcase
    end
    else if (pwr_pressed && !st_r.long_done)
    begin
      st_nxt.hold_cnt = st_r.hold_cnt + 32'h1; // RQ1
    end
    else if (press_fall && !st_r.long_done)
    begin
      // short action only on release, so a long hold never triggers it first
      st_nxt.chg = 1'h1; // RQ10
      case (st_r.sys)
        PSC_SYS_OFF:
        begin
          st_nxt.sys = PSC_SYS_WORK; // RQ2
        end
        PSC_SYS_WORK:
        begin
          st_nxt.sys = PSC_SYS_SLEEP; // RQ3
        end
        PSC_SYS_SLEEP:
        begin
          st_nxt.sys = PSC_SYS_WORK; // RQ5
        end
        default:
        begin
          st_nxt.sys = PSC_SYS_OFF;
          st_nxt.chg = 1'h0;
        end
      endcase
    end

    // supply rails only up in the working state; sleep keeps standby only
    st_nxt.psu_on = (st_nxt.sys == PSC_SYS_WORK); // RQ1

    // set wins over a clear in the same cycle
    if (cover_open)
    begin
      st_nxt.intrusion = 1'h1; // RQ9
    end
    else if (I_INTRUSION_CLR)
    begin
      st_nxt.intrusion = 1'h0;
    end

    // traffic keeps the blink alive for a while so short bursts stay visible
    if (!I_LINK_UP)
    begin
      st_nxt.act_cnt = `PSC_CNT_RST;
    end
    else if (I_LINK_ACT)
    begin
      st_nxt.act_cnt = 32'(ACT_HOLD_CYC); // RQ7
    end
    else if (st_r.act_cnt != `PSC_CNT_RST)
    begin
      st_nxt.act_cnt = st_r.act_cnt - 32'h1;
    end

    if (st_r.blink_cnt >= 32'(BLINK_HALF_CYC - 1))
    begin
      st_nxt.blink_cnt = `PSC_CNT_RST;
      st_nxt.blink = ~st_r.blink;
    end
    else
    begin
      st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
    end

    if (!I_LINK_UP)
    begin
      st_nxt.led_green = 1'h0; // RQ7
    end
    else if (st_nxt.act_cnt != `PSC_CNT_RST)
    begin
      st_nxt.led_green = st_r.blink; // RQ7
    end
    else
    begin
      st_nxt.led_green = 1'h1; // RQ7
    end

    st_nxt.led_yellow = I_LINK_FAST; // RQ8
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign O_SYS_STATE = st_r.sys;
  assign O_PSU_ON = st_r.psu_on;
  assign O_STATE_CHG = st_r.chg;
  assign O_INTRUSION = st_r.intrusion; // RQ9
  assign O_LED_GREEN = st_r.led_green;
  assign O_LED_YELLOW = st_r.led_yellow;

endmodule

// File: rtl/psc_regs.svh
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define PSC_CLK_MHZ 250
`define PSC_CYC_PER_MS (`PSC_CLK_MHZ * 1000)
`define PSC_HOLD_LONG_MS 4000
`define PSC_DEBOUNCE_MS 20
`define PSC_BLINK_HALF_MS 50
`define PSC_ACT_HOLD_MS 200
`define PSC_HOLD_LONG_CYC (`PSC_HOLD_LONG_MS * `PSC_CYC_PER_MS)
`define PSC_DEBOUNCE_CYC (`PSC_DEBOUNCE_MS * `PSC_CYC_PER_MS)
`define PSC_BLINK_HALF_CYC (`PSC_BLINK_HALF_MS * `PSC_CYC_PER_MS)
`define PSC_ACT_HOLD_CYC (`PSC_ACT_HOLD_MS * `PSC_CYC_PER_MS)

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PSC_SYS_RST 2'h0
`define PSC_CNT_RST 32'h0
`define PSC_BIT_RST 1'h0

`endif

// File: rtl/psc_pkg.sv
package psc_pkg;

  typedef enum logic [1:0]
  {
    PSC_SYS_OFF = 2'b00,
    PSC_SYS_WORK = 2'b01,
    PSC_SYS_SLEEP = 2'b10
  } psc_sys_t;

  typedef struct packed
  {
    logic level;
    logic [31:0] cnt;
  } psc_deb_t;

  typedef struct packed
  {
    psc_sys_t sys;
    logic psu_on;
    logic chg;
    logic sw_prev;
    logic long_done;
    logic [31:0] hold_cnt;
    logic intrusion;
    logic [31:0] blink_cnt;
    logic blink;
    logic [31:0] act_cnt;
    logic led_green;
    logic led_yellow;
  } psc_state_t;

endpackage

// File: rtl/psc_debounce.sv
`timescale 1ns/1ps
`include "psc_regs.svh"

module psc_debounce
  import psc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = `PSC_DEBOUNCE_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // raw and filtered level
  input wire logic i_raw,
  output logic o_level
);

  psc_deb_t st_r;
  psc_deb_t st_nxt;

  // the level only moves after the raw input has disagreed for a full window
  always_comb
  begin
    st_nxt = st_r;
    if (i_raw == st_r.level)
    begin
      st_nxt.cnt = `PSC_CNT_RST;
    end
    else if (st_r.cnt >= 32'(STABLE_CYC - 1))
    begin
      st_nxt.level = i_raw;
      st_nxt.cnt = `PSC_CNT_RST;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= '{level: `PSC_BIT_RST, cnt: `PSC_CNT_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule

// File: sim/psc_top_props.sv
`timescale 1ns/1ps
module psc_props
  import psc_pkg::*;
(
  // watched ports
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PWR_SW,
  input wire logic I_INTRUSION_CLR,
  input wire logic I_LINK_UP,
  input wire logic I_LINK_FAST,
  input wire logic [1:0] O_SYS_STATE,
  input wire logic O_PSU_ON,
  input wire logic O_STATE_CHG,
  input wire logic O_INTRUSION,
  input wire logic O_LED_GREEN,
  input wire logic O_LED_YELLOW
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sequence s_moved;
    O_SYS_STATE != $past(O_SYS_STATE);
  endsequence
  a_chg_marks_move: assert property (s_moved |-> O_STATE_CHG) else $error("state moved without pulse");
  a_chg_needs_move: assert property (O_STATE_CHG |-> s_moved) else $error("pulse without move");
  a_chg_one_cycle: assert property (O_STATE_CHG |=> !O_STATE_CHG) else $error("pulse too long");
  a_psu_tracks_work: assert property (O_PSU_ON == (O_SYS_STATE == PSC_SYS_WORK)) else $error("psu mismatch");
  a_state_legal: assert property (O_SYS_STATE != 2'h3) else $error("illegal state");
  a_short_on_release: assert property (s_moved ##0 O_SYS_STATE != PSC_SYS_OFF |-> !I_PWR_SW)
    else $error("short action while held");
  a_long_while_held: assert property (s_moved ##0 O_SYS_STATE == PSC_SYS_OFF |-> I_PWR_SW)
    else $error("off after release");
  a_sleep_from_work: assert property (s_moved ##0 O_SYS_STATE == PSC_SYS_SLEEP |-> $past(O_SYS_STATE) == PSC_SYS_WORK)
    else $error("sleep not from work");
  a_yellow_lag: assert property (!$past(I_RST) |-> O_LED_YELLOW == $past(I_LINK_FAST)) else $error("yellow lag");
  a_green_dark: assert property (!$past(I_LINK_UP) |-> !O_LED_GREEN) else $error("green lit without link");
  a_intr_sticky: assert property (O_INTRUSION && !I_INTRUSION_CLR |=> O_INTRUSION) else $error("flag lost");
endmodule

bind psc_top psc_props u_props (.I_CORE_CLK, .I_RST, .I_PWR_SW, .I_INTRUSION_CLR, .I_LINK_UP, .I_LINK_FAST,
  .O_SYS_STATE, .O_PSU_ON, .O_STATE_CHG, .O_INTRUSION, .O_LED_GREEN, .O_LED_YELLOW);

// File: sim/psc_panel.sv
`timescale 1ns/1ps
module psc_panel
(
  // clock seen by the switch
  input wire logic i_clk,
  // switch contact, high while pressed
  output logic o_sw
);
  initial o_sw = 1'b0;
  // contact moves on the falling edge only, away from sampling
  task automatic press(input int n);
    @(negedge i_clk);
    o_sw = 1'b1;
    repeat (n) @(negedge i_clk);
    o_sw = 1'b0;
  endtask
endmodule

// File: sim/power_switch_state_control_test.sv
`timescale 1ns/1ps
module power_switch_state_control_test;
  import psc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chas = 1'b0, clr = 1'b0, up = 1'b0, act = 1'b0, fast = 1'b0;
  logic sw, psu, chg, intr, grn, yel;
  logic [1:0] st;
  int n_mismatch = 0;
  int checked = 0;
  int n_chg = 0;
  always #2 clk = ~clk;
  psc_panel u_panel (.i_clk(clk), .o_sw(sw));
  psc_top #(.HOLD_LONG_CYC(40), .DEBOUNCE_CYC(4), .BLINK_HALF_CYC(3), .ACT_HOLD_CYC(20)) u_dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PWR_SW(sw), .I_CHASSIS_SW_CLOSED(chas), .I_INTRUSION_CLR(clr),
    .I_LINK_UP(up), .I_LINK_ACT(act), .I_LINK_FAST(fast), .O_SYS_STATE(st), .O_PSU_ON(psu),
    .O_STATE_CHG(chg), .O_INTRUSION(intr), .O_LED_GREEN(grn), .O_LED_YELLOW(yel));
  // the change pulse lasts one cycle, so exactly one falling edge sees it
  always @(negedge clk)
  begin
    if (chg === 1'b1)
      n_chg++;
  end
  // ----------------------------------------------------------------------------
  // compare and drive helpers
  // ----------------------------------------------------------------------------
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t state %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask
  // 12 cycles covers debounce of the release plus the two-edge answer
  task automatic go(input int n, input logic [1:0] exp);
    logic [1:0] was;
    int pulses;
    was = st;
    pulses = n_chg;
    u_panel.press(n);
    repeat (12) @(negedge clk);
    chk2(st, exp);
    chk1(psu, exp == 2'h1);
    chk1((n_chg - pulses) == ((exp != was) ? 1 : 0), 1'b1);
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_power;
    go(8, PSC_SYS_WORK);
    go(8, PSC_SYS_SLEEP);
    go(8, PSC_SYS_WORK);
    go(80, PSC_SYS_OFF);
    $display("t_power done");
  endtask
  task automatic t_long;
    go(2, PSC_SYS_OFF);
    go(80, PSC_SYS_OFF);
    go(8, PSC_SYS_WORK);
    go(8, PSC_SYS_SLEEP);
    go(80, PSC_SYS_OFF);
    $display("t_long done");
  endtask
  task automatic t_leds;
    int lows;
    lows = 0;
    fast = 1'b1;
    @(negedge clk);
    chk1(yel, 1'b1);
    chk1(grn, 1'b0);
    fast = 1'b0;
    up = 1'b1;
    repeat (2) @(negedge clk);
    chk1(grn, 1'b1);
    act = 1'b1;
    @(negedge clk);
    act = 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      lows += (grn === 1'b0);
    end
    chk1(lows > 0 && lows < 10, 1'b1);
    repeat (30) @(negedge clk);
    chk1(grn, 1'b1);
    up = 1'b0;
    repeat (2) @(negedge clk);
    chk1(grn, 1'b0);
    chk1(yel, 1'b0);
    $display("t_leds done");
  endtask
  task automatic t_intr;
    chas = 1'b1;
    repeat (8) @(negedge clk);
    clr = 1'b1;
    repeat (2) @(negedge clk);
    chk1(intr, 1'b1);
    chas = 1'b0;
    repeat (8) @(negedge clk);
    chk1(intr, 1'b0);
    clr = 1'b0;
    $display("t_intr done");
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk2(st, 2'h0);
    t_power;
    t_long;
    t_leds;
    t_intr;
    conclude;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule
